/* File: common/err_irq_pkg.sv */
package err_irq_pkg;
    // ------------------------------------------------------------------
    // Field widths and layouts
    // ------------------------------------------------------------------
    localparam int CODE_W = 4;
    localparam int RIS_W = 4;
    localparam int PID_W = 16;
    localparam int PMG_W = 8;
    localparam logic [CODE_W-1:0] CODE_NONE = 4'h0;
    localparam logic [RIS_W-1:0] RIS_NONE = 4'h0;
    localparam logic [PID_W-1:0] PID_ZERO = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Space select encodings on a request
    localparam logic SPACE_SECURE = 1'b0;
    localparam logic SPACE_NONSEC = 1'b1;
    localparam int SPACES = 2;
    localparam int IDX_S = 0;
    localparam int IDX_NS = 1;

    // Interrupt style
    typedef enum logic [0:0] {
        STYLE_LEVEL = 1'b0,
        STYLE_EDGE = 1'b1
    } irq_style_t;

    // Error status register contents
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [RIS_W-1:0] resource_instance_select;
        logic [PID_W-1:0] pid;
        logic [PMG_W-1:0] monitor_group;
    } err_status_t;

    localparam err_status_t STATUS_RESET = '{CODE_NONE, RIS_NONE, PID_ZERO, BYTE_ZERO};

    // Hardware error report
    typedef struct packed {
        logic valid;
        logic space;           // 0 Secure, 1 Non-secure
        logic is_monitor;      // Monitor access, else configuration access
        logic [CODE_W-1:0] code;
        logic [RIS_W-1:0] part_ris;
        logic [RIS_W-1:0] mon_ris;
        logic [PID_W-1:0] pid;
        logic [PMG_W-1:0] monitor_group;
    } err_report_t;

    // Software write to status or control
    typedef struct packed {
        logic wr_status;
        logic wr_control;
        logic space;
        err_status_t status;
        logic irq_en;
    } sw_write_t;

    // Error message write settings for one space
    typedef struct packed {
        logic [31:0] addr_lo;
        logic [31:0] addr_hi;
        logic [31:0] attr;
        logic [31:0] data;
        logic [PID_W-1:0] ptag;
    } msi_cfg_t;

    localparam msi_cfg_t MSI_RESET = '{WORD_ZERO, WORD_ZERO, WORD_ZERO, WORD_ZERO, PID_ZERO};

    // Outgoing message write request
    typedef struct packed {
        logic valid;
        logic space;
        msi_cfg_t cfg;
    } msi_req_t;

    // Capability flags in feature identification register
    typedef struct packed {
        logic msi_support_flag;
        logic status_present_flag;
    } feat_flags_t;
endpackage

/* File: logic/err_space_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module err_space_unit
    import err_irq_pkg::*;
#(
    parameter bit HAS_ERRORS = 1'b1,
    parameter irq_style_t STYLE = STYLE_LEVEL
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic hw_set,
    input wire err_status_t hw_status,
    input wire logic sw_status_wr,
    input wire logic sw_control_wr,
    input wire err_status_t sw_status,
    input wire logic sw_irq_en,
    output err_status_t status_r,
    output logic irq_en_r,
    output logic irq_r,
    output logic edge_r
);
    // ------------------------------------------------------------------
    // Status register; hardware set wins over software write
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            status_r <= STATUS_RESET;
        end else if (clk_en && HAS_ERRORS) begin
            if (hw_set) begin
                status_r <= hw_status;
            end else if (sw_status_wr) begin
                status_r <= sw_status;
            end
        end
    end

    // Control register, read-as-zero when no errors can occur
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_en_r <= 1'b0;
        end else if (clk_en && HAS_ERRORS && sw_control_wr) begin
            irq_en_r <= sw_irq_en;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output for this space only
    // ------------------------------------------------------------------
    // Level tracks the status code one cycle late; edge is a one-cycle
    // pulse on hardware writes only, so software writes never pulse.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
            edge_r <= 1'b0;
        end else if (clk_en) begin
            edge_r <= HAS_ERRORS && hw_set;
            if (STYLE == STYLE_LEVEL) begin
                irq_r <= irq_en_r && (status_r.code != CODE_NONE);
            end else begin
                irq_r <= HAS_ERRORS && hw_set && irq_en_r;
            end
        end
    end

    AST_LEVEL_FOLLOWS: assert property (@(posedge mclk) disable iff (!rst_b)
        (STYLE == STYLE_LEVEL && clk_en) |=>
        irq_r == ($past(irq_en_r) && $past(status_r.code) != CODE_NONE))
        else $error("level interrupt does not follow status code");
    AST_EDGE_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
        (STYLE == STYLE_EDGE && irq_r && clk_en && !hw_set) |=> !irq_r)
        else $error("edge interrupt longer than one cycle");
    AST_SW_NO_EDGE: assert property (@(posedge mclk) disable iff (!rst_b)
        (STYLE == STYLE_EDGE && clk_en && sw_status_wr && !hw_set) |=> !irq_r)
        else $error("software write produced an edge");
endmodule
`default_nettype wire

/* File: logic/partition_error_interrupt.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Record detected errors; interrupt only while the enable bit is one.
// - Without possible errors, status and control read zero, writes ignored.
// - Separate Secure and Non-secure status and control, each for own interrupt.
// - Interrupt style is level or edge, chosen by parameter.
// - Edge style is the default, since HAS_MSI defaults to one.
// - Two interrupt outputs, Secure and Non-secure.
// - Level style: interrupt asserted while error code is non-zero.
// - Level style: software non-zero code write activates interrupt.
// - Message write support forces edge style.
// - Edge style: hardware error write produces an edge.
// - Edge style: software status write produces no edge.
// - Feature flags report message support and status presence.
// - Each space holds its own message write configuration set.
// - Space select zero uses Secure settings, one uses Non-secure.
// - Out-of-range partition or group values get no defined outcome.
// - Capture partition or monitor select value into status instance field.
// - ID read with undefined instance: flags zero, no error, no interrupt.
module partition_error_interrupt
    import err_irq_pkg::*;
#(
    parameter bit HAS_ERRORS = 1'b1,
    parameter bit HAS_MSI = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire err_report_t err_in,
    input wire sw_write_t sw_in,
    input wire logic msi_cfg_wr,
    input wire logic msi_cfg_space,
    input wire msi_cfg_t msi_cfg_in,
    input wire logic id_rd,
    input wire logic id_ris_defined,
    output err_status_t status_s_r,
    output err_status_t status_ns_r,
    output logic irq_en_s_r,
    output logic irq_en_ns_r,
    output logic irq_s_r,
    output logic irq_ns_r,
    output msi_req_t msi_r,
    output feat_flags_t feat_r
);
    // ------------------------------------------------------------------
    // Style selection
    // ------------------------------------------------------------------
    // Message writes only make sense for edges, so their presence forces
    // edge style; otherwise level is used as the safer default.
    localparam irq_style_t STYLE = HAS_MSI ? STYLE_EDGE : STYLE_LEVEL;

    // Builds the captured status from a hardware report
    function automatic err_status_t capture(input err_report_t r);
        err_status_t s;
        s.code = r.code;
        s.resource_instance_select = r.is_monitor ? r.mon_ris : r.part_ris;
        s.pid = r.pid; // taken as is, no range check
        s.monitor_group = r.monitor_group;
        return s;
    endfunction

    // ------------------------------------------------------------------
    // Per-space routing of events
    // ------------------------------------------------------------------
    logic [SPACES-1:0] hw_set;
    logic [SPACES-1:0] sw_st_wr;
    logic [SPACES-1:0] sw_ct_wr;
    err_status_t hw_st;
    err_status_t st_q [SPACES];
    logic en_q [SPACES];
    logic lvl_q [SPACES];
    logic edge_q [SPACES];

    // A zero code is not an error and never marks a space
    always_comb begin
        hw_st = capture(err_in);
        hw_set[IDX_S] = err_in.valid && err_in.code != CODE_NONE
            && err_in.space == SPACE_SECURE;
        hw_set[IDX_NS] = err_in.valid && err_in.code != CODE_NONE
            && err_in.space == SPACE_NONSEC;
        sw_st_wr[IDX_S] = sw_in.wr_status && sw_in.space == SPACE_SECURE;
        sw_st_wr[IDX_NS] = sw_in.wr_status && sw_in.space == SPACE_NONSEC;
        sw_ct_wr[IDX_S] = sw_in.wr_control && sw_in.space == SPACE_SECURE;
        sw_ct_wr[IDX_NS] = sw_in.wr_control && sw_in.space == SPACE_NONSEC;
    end

    // One independent unit per space keeps the interrupts apart
    genvar g;
    generate
        for (g = 0; g < SPACES; g++) begin : gen_space
            err_space_unit #(
                .HAS_ERRORS(HAS_ERRORS),
                .STYLE(STYLE)
            ) u_space (
                .mclk(mclk),
                .rst_b(rst_b),
                .clk_en(clk_en),
                .hw_set(hw_set[g]),
                .hw_status(hw_st),
                .sw_status_wr(sw_st_wr[g]),
                .sw_control_wr(sw_ct_wr[g]),
                .sw_status(sw_in.status),
                .sw_irq_en(sw_in.irq_en),
                .status_r(st_q[g]),
                .irq_en_r(en_q[g]),
                .irq_r(lvl_q[g]),
                .edge_r(edge_q[g])
            );
        end
    endgenerate

    // Outputs are the units' own flip-flops
    assign status_s_r = st_q[IDX_S];
    assign status_ns_r = st_q[IDX_NS];
    assign irq_en_s_r = en_q[IDX_S];
    assign irq_en_ns_r = en_q[IDX_NS];
    assign irq_s_r = lvl_q[IDX_S];
    assign irq_ns_r = lvl_q[IDX_NS];

    // ------------------------------------------------------------------
    // Message write configuration, one set per space
    // ------------------------------------------------------------------
    msi_cfg_t msi_cfg_r [SPACES];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            msi_cfg_r[IDX_S] <= MSI_RESET;
            msi_cfg_r[IDX_NS] <= MSI_RESET;
        end else if (clk_en && HAS_MSI && msi_cfg_wr) begin
            msi_cfg_r[msi_cfg_space] <= msi_cfg_in;
        end
    end

    // ------------------------------------------------------------------
    // Message write request
    // ------------------------------------------------------------------
    // Secure wins if both spaces pulse at once; the reporting port carries
    // one error per cycle, so that never occurs in practice.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            msi_r <= '{1'b0, SPACE_SECURE, MSI_RESET};
        end else if (clk_en) begin
            msi_r.valid <= 1'b0;
            if (HAS_MSI && hw_set[IDX_S] && en_q[IDX_S]) begin
                msi_r.valid <= 1'b1;
                msi_r.space <= SPACE_SECURE;
                msi_r.cfg <= msi_cfg_r[IDX_S];
            end else if (HAS_MSI && hw_set[IDX_NS] && en_q[IDX_NS]) begin
                msi_r.valid <= 1'b1;
                msi_r.space <= SPACE_NONSEC;
                msi_r.cfg <= msi_cfg_r[IDX_NS];
            end
        end
    end

    // ------------------------------------------------------------------
    // Feature identification flags
    // ------------------------------------------------------------------
    // An undefined instance reads all flags as zero and never errors.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            feat_r <= '0;
        end else if (clk_en && id_rd) begin
            feat_r.msi_support_flag <= id_ris_defined && HAS_MSI;
            feat_r.status_present_flag <= id_ris_defined && HAS_ERRORS;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence hw_err_s;
        clk_en && err_in.valid && err_in.code != CODE_NONE && err_in.space == SPACE_SECURE;
    endsequence

    sequence captured_s;
        ##1 status_s_r.code == $past(err_in.code);
    endsequence

    AST_RECORD: assert property (@(posedge mclk) disable iff (!rst_b)
        (hw_err_s and (HAS_ERRORS == 1'b1)) |-> captured_s)
        else $error("error not recorded in Secure status");
    AST_RIS_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_b)
        (HAS_ERRORS && clk_en && err_in.valid && err_in.code != CODE_NONE
        && err_in.space == SPACE_NONSEC) |=>
        status_ns_r.resource_instance_select == ($past(err_in.is_monitor) ? $past(err_in.mon_ris)
        : $past(err_in.part_ris)))
        else $error("instance field captured wrongly");
    AST_NO_IRQ_DISABLED: assert property (@(posedge mclk) disable iff (!rst_b)
        (clk_en && !irq_en_s_r) |=> !irq_s_r)
        else $error("Secure interrupt raised while disabled");
    AST_SPACE_ISOLATION: assert property (@(posedge mclk) disable iff (!rst_b)
        (hw_err_s and (STYLE == STYLE_EDGE)) |=> !irq_ns_r)
        else $error("Secure error raised Non-secure interrupt");
    AST_MSI_SPACE: assert property (@(posedge mclk) disable iff (!rst_b)
        msi_r.valid |-> msi_r.cfg == (msi_r.space ? $past(msi_cfg_r[IDX_NS])
        : $past(msi_cfg_r[IDX_S])))
        else $error("message write used wrong space settings");
    AST_UNDEF_FLAGS: assert property (@(posedge mclk) disable iff (!rst_b)
        (clk_en && id_rd && !id_ris_defined) |=> feat_r == '0)
        else $error("flags not zero for undefined instance");
    AST_RAZ: assert property (@(posedge mclk) disable iff (!rst_b)
        !HAS_ERRORS |-> (status_s_r == STATUS_RESET && !irq_en_ns_r))
        else $error("status not read-as-zero");
    AST_MSI_EDGE: assert property (@(posedge mclk) disable iff (!rst_b)
        (HAS_MSI && clk_en && sw_in.wr_status && !err_in.valid) |=> !irq_s_r && !irq_ns_r)
        else $error("message-capable block not edge style");
    // An edge-style pulse must always coincide with a hardware write marker
    AST_EDGE_FROM_HW: assert property (@(posedge mclk) disable iff (!rst_b)
        (STYLE == STYLE_EDGE) |->
        ((!irq_s_r || edge_q[IDX_S]) && (!irq_ns_r || edge_q[IDX_NS])))
        else $error("edge interrupt without a hardware error write");
endmodule
`default_nettype wire

/* File: tb/irq_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_sink
    import err_irq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic irq_s,
    input wire logic irq_ns,
    input wire msi_req_t msi,
    output int edges_s,
    output int edges_ns,
    output int msgs_s,
    output int msgs_ns
);
    logic irq_s_d;
    logic irq_ns_d;

    // Edge-sensitive receiver: every rising edge is a new request, nothing is acknowledged
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_s_d <= 1'b0;
            irq_ns_d <= 1'b0;
            edges_s <= 0;
            edges_ns <= 0;
            msgs_s <= 0;
            msgs_ns <= 0;
        end else begin
            irq_s_d <= irq_s;
            irq_ns_d <= irq_ns;
            if (irq_s === 1'b1 && irq_s_d === 1'b0) edges_s <= edges_s + 1;
            if (irq_ns === 1'b1 && irq_ns_d === 1'b0) edges_ns <= edges_ns + 1;
            // Message writes are sorted by the space they claim to belong to
            if (msi.valid === 1'b1 && msi.space === SPACE_SECURE) msgs_s <= msgs_s + 1;
            if (msi.valid === 1'b1 && msi.space === SPACE_NONSEC) msgs_ns <= msgs_ns + 1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import err_irq_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    err_report_t err_in = '0;
    sw_write_t sw_in = '0;
    logic msi_cfg_wr = 1'b0;
    logic msi_cfg_space = 1'b0;
    msi_cfg_t msi_cfg_in = '0;
    logic id_rd = 1'b0;
    logic id_ris_defined = 1'b1;
    err_status_t st_s [3];
    err_status_t st_ns [3];
    logic en_s [3];
    logic en_ns [3];
    logic irq_s [3];
    logic irq_ns [3];
    msi_req_t msi [3];
    feat_flags_t feat [3];
    int p_edges [2];
    int p_msgs [2];
    int err_total = 0;
    int checks_done = 0;
    msi_cfg_t cfg_exp [2];
    err_status_t exp_st [2];
    logic exp_en [2];
    int exp_edges [2] = '{0, 0};

    // ------------------------------------------------------------------
    // Edge style, level style and no-error variants side by side
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : dut
        partition_error_interrupt #(.HAS_ERRORS(g != 2), .HAS_MSI(g == 0)) uut (
            .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .err_in(err_in), .sw_in(sw_in),
            .msi_cfg_wr(msi_cfg_wr), .msi_cfg_space(msi_cfg_space), .msi_cfg_in(msi_cfg_in),
            .id_rd(id_rd), .id_ris_defined(id_ris_defined), .status_s_r(st_s[g]),
            .status_ns_r(st_ns[g]), .irq_en_s_r(en_s[g]), .irq_en_ns_r(en_ns[g]),
            .irq_s_r(irq_s[g]), .irq_ns_r(irq_ns[g]), .msi_r(msi[g]), .feat_r(feat[g]));
    end

    irq_sink sink (.mclk(mclk), .rst_b(rst_b), .irq_s(irq_s[0]), .irq_ns(irq_ns[0]),
        .msi(msi[0]), .edges_s(p_edges[0]), .edges_ns(p_edges[1]), .msgs_s(p_msgs[0]),
        .msgs_ns(p_msgs[1]));

    initial begin
        forever #2 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------------
    task automatic chk_val(input string what, input logic [159:0] want, input logic [159:0] got);
        checks_done++;
        if (got !== want) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, want, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int want, input int got);
        checks_done++;
        if (got != want) begin
            err_total++;
            $display("Error %s expected %0d seen %0d", what, want, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic err_status_t exp_status(input err_report_t r);
        exp_status = '{r.code, r.is_monitor ? r.mon_ris : r.part_ris, r.pid, r.monitor_group};
    endfunction

    // Settled state of all three variants against the bench's own bookkeeping
    task automatic chk_state();
        for (int i = 0; i < 2; i++) begin
            chk_val("status_s", exp_st[0], st_s[i]);
            chk_val("status_ns", exp_st[1], st_ns[i]);
            chk_val("enable_s", exp_en[0], en_s[i]);
            chk_val("enable_ns", exp_en[1], en_ns[i]);
        end
        chk_val("edge_quiet", 2'b00, {irq_s[0], irq_ns[0]});
        chk_val("level_irq_s", exp_en[0] && exp_st[0].code != CODE_NONE, irq_s[1]);
        chk_val("level_irq_ns", exp_en[1] && exp_st[1].code != CODE_NONE, irq_ns[1]);
        chk_val("raz_regs", '0, {st_s[2], st_ns[2], en_s[2], en_ns[2], irq_s[2], irq_ns[2]});
    endtask

    // ------------------------------------------------------------------
    // Stimulus tasks, all driven at the falling edge
    // ------------------------------------------------------------------
    task automatic hw_err(input err_report_t r);
        logic hit;
        hit = r.code != CODE_NONE && clk_en;
        @(negedge mclk);
        err_in = r;
        @(negedge mclk);
        err_in.valid = 1'b0;
        if (hit) exp_st[r.space] = exp_status(r);
        hit = hit && exp_en[r.space];
        // Pulse and message stand only until the next rising edge
        chk_val("edge_irq_s", hit && r.space == SPACE_SECURE, irq_s[0]);
        chk_val("edge_irq_ns", hit && r.space == SPACE_NONSEC, irq_ns[0]);
        chk_val("msi_valid", hit, msi[0].valid);
        chk_val("msi_quiet", 2'b00, {msi[1].valid, msi[2].valid});
        if (hit) begin
            chk_val("msi_space", r.space, msi[0].space);
            chk_val("msi_cfg", cfg_exp[r.space], msi[0].cfg);
            exp_edges[r.space]++;
        end
        @(negedge mclk);
        chk_state();
    endtask

    task automatic sw_wr(input logic sp, input logic ws, input logic wc, input err_status_t st,
                         input logic en);
        @(negedge mclk);
        sw_in = '{ws, wc, sp, st, en};
        @(negedge mclk);
        sw_in.wr_status = 1'b0;
        sw_in.wr_control = 1'b0;
        if (ws) exp_st[sp] = st;
        if (wc) exp_en[sp] = en;
        // A pulse from this write would stand right here
        chk_val("sw_no_edge", 2'b00, {irq_s[0], irq_ns[0]});
        @(negedge mclk);
        chk_state();
    endtask

    task automatic cfg_wr(input logic sp);
        @(negedge mclk);
        cfg_exp[sp] = {$urandom, $urandom, $urandom, $urandom, 16'($urandom)};
        msi_cfg_wr = 1'b1;
        msi_cfg_space = sp;
        msi_cfg_in = cfg_exp[sp];
        @(negedge mclk);
        msi_cfg_wr = 1'b0;
    endtask

    task automatic id_read(input logic defd);
        @(negedge mclk);
        id_rd = 1'b1;
        id_ris_defined = defd;
        @(negedge mclk);
        id_rd = 1'b0;
        @(negedge mclk);
        chk_val("feat_edge", {defd, defd}, feat[0]);
        chk_val("feat_level", {1'b0, defd}, feat[1]);
        chk_val("feat_raz", 2'b00, feat[2]);
        chk_state();
    endtask

    // Hang guard: fixed latencies only, so anything this long is a stuck run
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        err_report_t r;
        void'($urandom(14));
        exp_st = '{STATUS_RESET, STATUS_RESET};
        exp_en = '{1'b0, 1'b0};
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        chk_state();
        cfg_wr(SPACE_SECURE);
        cfg_wr(SPACE_NONSEC);
        sw_wr(SPACE_SECURE, 1'b0, 1'b1, STATUS_RESET, 1'b1);
        sw_wr(SPACE_NONSEC, 1'b0, 1'b1, STATUS_RESET, 1'b1);
        // Identifiers stay inside the field widths the block takes
        for (int n = 0; n < 20; n++) begin
            r = '{1'b1, 1'($urandom), 1'($urandom), 4'($urandom_range(15, 1)), 4'($urandom),
                  4'($urandom), 16'($urandom), 8'($urandom)};
            hw_err(r);
            if (n % 3 == 2) sw_wr(r.space, 1'b1, 1'b0, STATUS_RESET, 1'b0);
        end
        // Zero code and a frozen clock enable must both leave everything alone
        r.code = CODE_NONE;
        hw_err(r);
        clk_en = 1'b0;
        r.code = 4'hA;
        hw_err(r);
        clk_en = 1'b1;
        // Secure disabled: still recorded, no interrupt, other space unaffected
        sw_wr(SPACE_SECURE, 1'b0, 1'b1, STATUS_RESET, 1'b0);
        r.space = SPACE_SECURE;
        hw_err(r);
        r.space = SPACE_NONSEC;
        r.is_monitor = 1'b1;
        hw_err(r);
        sw_wr(SPACE_SECURE, 1'b0, 1'b1, STATUS_RESET, 1'b1);
        sw_wr(SPACE_NONSEC, 1'b1, 1'b0, STATUS_RESET, 1'b0);
        sw_wr(SPACE_NONSEC, 1'b1, 1'b0, '{4'hF, 4'h3, 16'hFFFF, 8'hFF}, 1'b0);
        sw_wr(SPACE_NONSEC, 1'b1, 1'b0, STATUS_RESET, 1'b0);
        sw_wr(SPACE_SECURE, 1'b1, 1'b0, STATUS_RESET, 1'b0);
        id_read(1'b1);
        id_read(1'b0);
        repeat (2) @(negedge mclk);
        for (int s = 0; s < 2; s++) begin
            chk_cnt("irq_edges", exp_edges[s], p_edges[s]);
            chk_cnt("msi_writes", exp_edges[s], p_msgs[s]);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
